// ---- inc/dual_adc_params.svh ----
// What this block does
// RL1: Unused serial port: data pin is static powerdown input
// RL2: Chip select held high disables serial port
// RL3: Map: config 0x00-0x02, index/update 0x05/0xFF, program 0x08-0x25
// RL4: Host writes zeros into unused register bits
// RL5: Host never writes unsupported addresses
// RL6: Reset loads documented defaults
// RL7: Program registers shadowed until update command
// RL8: Writing 0x01 to 0xFF copies shadows together
// RL9: Update bit clears itself after the copy
// RL10: Local registers duplicated, steered by 0x05 bits 0/1
// RL11: Both selects set: write updates both copies
// RL12: Read with both selects returns channel A
// RL13: Global registers ignore channel selects
// RL14: Port config mirrored bits, default 0x18
// RL15: MSB first until port config selects LSB first
// RL16: Frame: 16-bit instruction then 8-bit data words
// RL17: Low registers take effect at end of byte
`ifndef DUAL_ADC_PARAMS_SVH
`define DUAL_ADC_PARAMS_SVH

`define ADDR_PORT_CFG 13'h0000
`define ADDR_CHIP_ID 13'h0001
`define ADDR_CHIP_GRADE 13'h0002
`define ADDR_CHAN_SEL 13'h0005
`define ADDR_UPDATE 13'h00FF
`define ADDR_PROG_FIRST 13'h0008
`define ADDR_PROG_LAST 13'h0025
`define ADDR_MODES 13'h0008
`define ADDR_CLOCK 13'h0009
`define ADDR_TEST_MODE 13'h000D

`define PORT_CFG_DEFAULT 8'h18
`define PORT_CFG_LSB_HI 6
`define PORT_CFG_LSB_LO 1
`define PORT_CFG_RST_HI 5
`define PORT_CFG_RST_LO 2
`define CHAN_SEL_DEFAULT 2'h3
`define UPDATE_BIT 0
`define CLOCK_DEFAULT 8'h01
`define PROG_DEFAULT 8'h00
`define CHIP_GRADE_VALUE 8'h00
`define MODE_FULL_PD 2'h1

`define INSTR_BITS 16
`define DATA_BITS 8
`define FRAME_BITS 24

`define CLK_PERIOD_NS 8
`define SCLK_HALF_NS 32
`define SCLK_HALF_CYC ((`SCLK_HALF_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`define HOST_REG_CTRL 2'h0
`define HOST_REG_ADDR 2'h1
`define HOST_REG_WDATA 2'h2
`define HOST_REG_STATUS 2'h3
`define CTRL_GO 0
`define CTRL_READ 1
`define CTRL_LSB 2
`define CTRL_STATIC_DRIVE 3
`define CTRL_STATIC_LEVEL 4

`endif

// ---- inc/dual_adc_pkg.sv ----
package dual_adc_pkg;

    typedef enum logic [1:0] {
        PH_INSTR,
        PH_DATA,
        PH_DONE
    } dev_phase_e;

    typedef enum logic [1:0] {
        H_IDLE,
        H_SHIFT,
        H_GAP
    } host_state_e;

endpackage : dual_adc_pkg

// ---- inc/serial_port_if.sv ----
`timescale 1ns/100ps
interface serial_port_if;
    logic sclk;
    logic port_select_n;
    logic host_sdio;
    logic host_sdio_oe;
    logic dev_sdio;
    logic dev_sdio_oe;
    logic serial_data_powerdown_pin;

    // Undriven line rests at the supply level
    assign serial_data_powerdown_pin = host_sdio_oe ? host_sdio :
                                       (dev_sdio_oe ? dev_sdio : 1'b1);

    modport host (
        output sclk,
        output port_select_n,
        output host_sdio,
        output host_sdio_oe,
        input serial_data_powerdown_pin
    );

    modport device (
        input sclk,
        input port_select_n,
        input serial_data_powerdown_pin,
        output dev_sdio,
        output dev_sdio_oe
    );
endinterface : serial_port_if

// ---- hdl/adc_serial_regs.sv ----
`timescale 1ns/100ps
`include "dual_adc_params.svh"

module adc_serial_regs
    import dual_adc_pkg::*;
#(
    parameter logic [7:0] CHIP_ID = 8'h5C, // Arbitrary identification value
    parameter int NPROG = 30
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Serial port
    serial_port_if.device port,
    // Device controls
    output logic powerdown_o,
    output logic lsb_first_o,
    output logic [1:0] chan_sel_o,
    output logic [NPROG-1:0][7:0] prog_active_a_o,
    output logic [NPROG-1:0][7:0] prog_active_b_o
);

    typedef logic [NPROG-1:0][7:0] prog_t;

    typedef struct packed {
        logic sclk;
        dev_phase_e phase;
        logic [4:0] cnt;
        logic [15:0] sh;
        logic rd;
        logic [1:0] len;
        logic [1:0] nbytes;
        logic [12:0] addr;
        logic [7:0] tx;
        logic sdo;
        logic oe;
        logic lsb;
        logic [1:0] chan;
        logic used;
        prog_t sa;
        prog_t sb;
        prog_t aa;
        prog_t ab;
    } dev_s;

    dev_s s_q;
    dev_s s_d;
    logic rise;
    logic fall;
    logic bit_in;
    logic [7:0] byte_v;
    logic [12:0] next_addr;

    function automatic prog_t prog_defaults();
        prog_t v;
        for (int i = 0; i < NPROG; i++) begin
            v[i] = (i == int'(`ADDR_CLOCK - `ADDR_PROG_FIRST)) ? `CLOCK_DEFAULT : `PROG_DEFAULT;
        end
        return v;
    endfunction : prog_defaults

    function automatic logic in_prog(input logic [12:0] a);
        return (a >= `ADDR_PROG_FIRST) && (a <= `ADDR_PROG_LAST);
    endfunction : in_prog

    function automatic logic is_local(input logic [12:0] a);
        return a == `ADDR_TEST_MODE;
    endfunction : is_local

    function automatic logic [7:0] port_cfg_value(input logic lsb);
        logic [7:0] v;
        v = `PORT_CFG_DEFAULT;
        v[`PORT_CFG_LSB_HI] = lsb;
        v[`PORT_CFG_LSB_LO] = lsb;
        return v;
    endfunction : port_cfg_value

    function automatic logic [7:0] rd_val(input dev_s s, input logic [12:0] a);
        logic [7:0] v;
        logic [12:0] idx;
        v = 8'h00;
        idx = a - `ADDR_PROG_FIRST;
        if (a == `ADDR_PORT_CFG) begin
            v = port_cfg_value(s.lsb); // [RL14]
        end else if (a == `ADDR_CHIP_ID) begin
            v = CHIP_ID;
        end else if (a == `ADDR_CHIP_GRADE) begin
            v = `CHIP_GRADE_VALUE;
        end else if (a == `ADDR_CHAN_SEL) begin
            v = {6'h00, s.chan};
        end else if (in_prog(a)) begin
            // Both selects set reads channel A
            if (is_local(a) && s.chan == 2'h2) begin // [RL12]
                v = s.sb[idx];
            end else begin
                v = s.sa[idx]; // [RL13]
            end
        end
        return v;
    endfunction : rd_val

    function automatic dev_s reset_state();
        dev_s r;
        r = '0;
        r.phase = PH_INSTR;
        r.lsb = 1'b0; // [RL15]
        r.chan = `CHAN_SEL_DEFAULT;
        r.sa = prog_defaults(); // [RL6]
        r.sb = prog_defaults();
        r.aa = prog_defaults();
        r.ab = prog_defaults();
        return r;
    endfunction : reset_state

    assign bit_in = port.serial_data_powerdown_pin;
    assign rise = port.sclk & ~s_q.sclk;
    assign fall = ~port.sclk & s_q.sclk;

    always_comb begin
        s_d = s_q;
        byte_v = 8'h00;
        next_addr = s_q.addr;
        s_d.sclk = port.sclk;
        if (port.port_select_n) begin
            // Chip select high: port idle; data pin is static powerdown only before any frame
            s_d.phase = PH_INSTR; // [RL2]
            s_d.cnt = 5'd0;
            s_d.oe = 1'b0;
        end else if (rise) begin
            s_d.used = 1'b1;
            s_d.sh = s_q.lsb ? {bit_in, s_q.sh[15:1]} : {s_q.sh[14:0], bit_in}; // [RL15]
            s_d.cnt = s_q.cnt + 5'd1;
            if (s_q.phase == PH_INSTR && s_q.cnt == 5'(`INSTR_BITS - 1)) begin // [RL16]
                s_d.rd = s_d.sh[15];
                s_d.len = s_d.sh[14:13];
                s_d.addr = s_d.sh[12:0];
                s_d.phase = PH_DATA;
                s_d.cnt = 5'd0;
                s_d.nbytes = 2'd0;
                s_d.tx = rd_val(s_q, s_d.sh[12:0]);
            end else if (s_q.phase == PH_DATA && s_q.cnt == 5'(`DATA_BITS - 1)) begin // [RL16]
                byte_v = s_q.lsb ? s_d.sh[15:8] : s_d.sh[7:0];
                s_d.cnt = 5'd0;
                // Address walks down in MSB-first mode, up in LSB-first
                next_addr = s_q.lsb ? s_q.addr + 13'd1 : s_q.addr - 13'd1;
                if (!s_q.rd) begin
                    if (s_q.addr == `ADDR_PORT_CFG) begin
                        s_d.lsb = byte_v[`PORT_CFG_LSB_HI] | byte_v[`PORT_CFG_LSB_LO]; // [RL14] [RL17]
                        if (byte_v[`PORT_CFG_RST_HI] | byte_v[`PORT_CFG_RST_LO]) begin // [RL14]
                            // Soft reset reloads defaults and never reads back set
                            s_d.lsb = 1'b0;
                            s_d.chan = `CHAN_SEL_DEFAULT;
                            s_d.sa = prog_defaults(); // [RL6]
                            s_d.sb = prog_defaults();
                            s_d.aa = prog_defaults();
                            s_d.ab = prog_defaults();
                        end
                    end else if (s_q.addr == `ADDR_CHAN_SEL) begin
                        s_d.chan = byte_v[1:0]; // [RL10] [RL17]
                    end else if (s_q.addr == `ADDR_UPDATE) begin
                        // Command bit is not stored, so it reads back clear
                        if (byte_v[`UPDATE_BIT]) begin // [RL8] [RL9]
                            s_d.aa = s_q.sa;
                            s_d.ab = s_q.sb;
                        end
                    end else if (in_prog(s_q.addr)) begin // [RL3] [RL7]
                        if (is_local(s_q.addr)) begin
                            if (s_q.chan[0]) begin // [RL10] [RL11]
                                s_d.sa[s_q.addr - `ADDR_PROG_FIRST] = byte_v;
                            end
                            if (s_q.chan[1]) begin // [RL10] [RL11]
                                s_d.sb[s_q.addr - `ADDR_PROG_FIRST] = byte_v;
                            end
                        end else begin
                            // Global: one value, mirrored to keep both outputs equal
                            s_d.sa[s_q.addr - `ADDR_PROG_FIRST] = byte_v; // [RL13]
                            s_d.sb[s_q.addr - `ADDR_PROG_FIRST] = byte_v;
                        end
                    end
                end
                s_d.addr = next_addr;
                s_d.nbytes = s_q.nbytes + 2'd1;
                if (s_q.len != 2'h3 && s_q.nbytes == s_q.len) begin
                    s_d.phase = PH_DONE;
                end
                s_d.tx = rd_val(s_d, next_addr);
            end
        end else if (fall) begin
            if (s_q.phase == PH_DATA && s_q.rd) begin
                s_d.sdo = s_q.lsb ? s_q.tx[0] : s_q.tx[7];
                s_d.tx = s_q.lsb ? {1'b0, s_q.tx[7:1]} : {s_q.tx[6:0], 1'b0};
                s_d.oe = 1'b1;
            end else begin
                s_d.oe = 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q <= reset_state(); // [RL6]
        end else begin
            s_q <= s_d;
        end
    end

    assign port.dev_sdio = s_q.sdo;
    assign port.dev_sdio_oe = s_q.oe & ~port.port_select_n;
    // Before any frame the data pin is the static powerdown control
    assign powerdown_o = s_q.used ? (s_q.aa[0][1:0] == `MODE_FULL_PD) : bit_in; // [RL1]
    assign lsb_first_o = s_q.lsb;
    assign chan_sel_o = s_q.chan;
    assign prog_active_a_o = s_q.aa;
    assign prog_active_b_o = s_q.ab;

endmodule : adc_serial_regs

// ---- hdl/serial_port_host.sv ----
`timescale 1ns/100ps
`include "dual_adc_params.svh"

module serial_port_host
    import dual_adc_pkg::*;
#(
    parameter int SCLK_HALF = `SCLK_HALF_CYC
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [3:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // Serial port
    serial_port_if.host port
);

    typedef struct packed {
        host_state_e state;
        logic [7:0] div;
        logic sclk;
        logic select_n;
        logic sdo;
        logic oe;
        logic [23:0] sh;
        logic [4:0] bitn;
        logic rd;
        logic lsb;
        logic [7:0] rdata;
        logic cfg_rd;
        logic cfg_lsb;
        logic static_drive;
        logic static_level;
        logic [12:0] addr;
        logic [7:0] wdata;
        logic ack;
        logic [31:0] dat;
    } host_s;

    host_s s_q;
    host_s s_d;
    logic req;
    logic half_done;

    assign req = cyc_i & stb_i & ~s_q.ack;
    assign half_done = s_q.div == 8'(SCLK_HALF - 1);

    always_comb begin
        s_d = s_q;
        s_d.ack = req;
        if (req && !we_i) begin
            s_d.dat = 32'h0000_0000;
            unique case (adr_i[3:2])
                `HOST_REG_CTRL: s_d.dat[4:1] = {s_q.static_level, s_q.static_drive,
                                               s_q.cfg_lsb, s_q.cfg_rd};
                `HOST_REG_ADDR: s_d.dat[12:0] = s_q.addr;
                `HOST_REG_WDATA: s_d.dat[7:0] = s_q.wdata;
                `HOST_REG_STATUS: s_d.dat[15:0] = {s_q.rdata, 7'h00, s_q.state != H_IDLE};
            endcase
        end
        if (req && we_i) begin
            if (adr_i[3:2] == `HOST_REG_CTRL && sel_i[0]) begin
                s_d.cfg_rd = dat_i[`CTRL_READ];
                s_d.cfg_lsb = dat_i[`CTRL_LSB];
                s_d.static_drive = dat_i[`CTRL_STATIC_DRIVE];
                s_d.static_level = dat_i[`CTRL_STATIC_LEVEL];
            end
            if (adr_i[3:2] == `HOST_REG_ADDR) begin
                if (sel_i[0]) s_d.addr[7:0] = dat_i[7:0];
                if (sel_i[1]) s_d.addr[12:8] = dat_i[12:8];
            end
            if (adr_i[3:2] == `HOST_REG_WDATA && sel_i[0]) begin
                s_d.wdata = dat_i[7:0]; // [RL4]
            end
        end
        s_d.div = half_done ? 8'd0 : s_q.div + 8'd1;
        unique case (s_q.state)
            H_IDLE: begin
                s_d.div = 8'd0;
                s_d.oe = s_q.static_drive;
                s_d.sdo = s_q.static_level; // [RL1]
                // Start is ignored while a frame runs
                if (req && we_i && adr_i[3:2] == `HOST_REG_CTRL && sel_i[0]
                    && dat_i[`CTRL_GO]) begin
                    s_d.state = H_SHIFT;
                    s_d.select_n = 1'b0;
                    s_d.rd = dat_i[`CTRL_READ];
                    s_d.lsb = dat_i[`CTRL_LSB]; // [RL15]
                    s_d.sh = dat_i[`CTRL_LSB] ? {s_d.wdata, {dat_i[`CTRL_READ], 2'b00, s_d.addr}}
                                              : {{dat_i[`CTRL_READ], 2'b00, s_d.addr}, s_d.wdata};
                    s_d.sdo = dat_i[`CTRL_LSB] ? s_d.sh[0] : s_d.sh[23];
                    s_d.oe = 1'b1;
                    // Single-byte frame: direction, length field zero, address
                    s_d.bitn = 5'd0; // [RL16]
                end
            end
            H_SHIFT: begin
                if (half_done && !s_q.sclk) begin
                    s_d.sclk = 1'b1;
                    if (s_q.rd && s_q.bitn >= 5'(`INSTR_BITS)) begin
                        s_d.rdata = s_q.lsb ? {port.serial_data_powerdown_pin, s_q.rdata[7:1]}
                                            : {s_q.rdata[6:0], port.serial_data_powerdown_pin};
                    end
                end else if (half_done && s_q.sclk) begin
                    s_d.sclk = 1'b0;
                    s_d.sh = s_q.lsb ? {1'b0, s_q.sh[23:1]} : {s_q.sh[22:0], 1'b0};
                    s_d.sdo = s_q.lsb ? s_d.sh[0] : s_d.sh[23];
                    s_d.bitn = s_q.bitn + 5'd1;
                    // Release the line during read data
                    s_d.oe = !(s_q.rd && s_q.bitn >= 5'(`INSTR_BITS - 1));
                    if (s_q.bitn == 5'(`FRAME_BITS - 1)) begin // [RL16]
                        s_d.state = H_GAP;
                        s_d.oe = 1'b0;
                    end
                end
            end
            H_GAP: begin
                s_d.oe = 1'b0;
                if (half_done) begin
                    s_d.select_n = 1'b1;
                    s_d.state = H_IDLE;
                end
            end
            default: begin
                s_d.state = H_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q <= '{state: H_IDLE, select_n: 1'b1, default: '0};
        end else begin
            s_q <= s_d;
        end
    end

    assign dat_o = s_q.dat;
    assign ack_o = s_q.ack;
    assign port.sclk = s_q.sclk;
    assign port.port_select_n = s_q.select_n;
    assign port.host_sdio = s_q.sdo;
    assign port.host_sdio_oe = s_q.oe;

endmodule : serial_port_host

// ---- test/dual_adc_props.sv ----
`timescale 1ns/100ps
module dual_adc_props #(
    parameter int HALF = 2
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Serial link
    input wire logic sclk,
    input wire logic port_select_n,
    input wire logic host_sdio,
    input wire logic host_sdio_oe,
    input wire logic dev_sdio,
    input wire logic dev_sdio_oe,
    input wire logic serial_data_powerdown_pin
);
    logic sclk_q;
    logic [5:0] rise_q;
    logic [7:0] high_q;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    // Counts rises inside a frame, cleared while deselected
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sclk_q <= 1'b0;
            rise_q <= 6'h00;
            high_q <= 8'h00;
        end else begin
            sclk_q <= sclk;
            if (port_select_n) begin
                rise_q <= 6'h00;
            end else if (sclk && !sclk_q) begin
                rise_q <= rise_q + 6'h01;
            end
            if (!sclk) begin
                high_q <= 8'h00;
            end else begin
                high_q <= high_q + 8'h01;
            end
        end
    end

    a_drive_needs_select: assert property (dev_sdio_oe |-> !port_select_n)
        else $error("device drives the data line while deselected");
    a_single_driver: assert property (!(host_sdio_oe && dev_sdio_oe))
        else $error("both ends drive the data line");
    a_idle_clock_low: assert property (port_select_n |-> !sclk)
        else $error("serial clock moves while deselected");
    a_reset_idle: assert property (disable iff (1'b0) rst_i |=>
        port_select_n && !sclk && !host_sdio_oe && !dev_sdio_oe)
        else $error("link not idle after reset");
    a_frame_bit_count: assert property ($rose(port_select_n) |-> rise_q == 6'd24)
        else $error("frame did not carry 24 clock rises");
    a_clock_high_time: assert property ($fell(sclk) |-> high_q == HALF)
        else $error("serial clock high time wrong");
    a_data_stable_high: assert property (sclk && $past(sclk) && host_sdio_oe
        && $past(host_sdio_oe) |-> $stable(host_sdio))
        else $error("host data changed while clock high");
    a_turnaround_late: assert property (dev_sdio_oe |-> rise_q >= 6'd16)
        else $error("device drives before instruction ends");
    a_frame_bounded: assert property ($fell(port_select_n) |->
        ##[1:1000] $rose(port_select_n))
        else $error("frame never ended");
endmodule : dual_adc_props

// ---- test/dual_adc_spi_register_map_bench.sv ----
`timescale 1ns/100ps
module dual_adc_spi_register_map_bench;
    localparam int HALF = 2;
    localparam int LIMIT = 60000;

    typedef struct packed {
        logic wr;
        logic [12:0] addr;
        logic [7:0] data;
        logic [7:0] exp;
    } row_s;

    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [3:0] adr = 4'h0;
    logic [3:0] sel = 4'h0;
    logic [31:0] dat_w = 32'h0000_0000;
    logic [31:0] dat_r;
    logic ack;
    logic powerdown;
    logic lsb_first;
    logic [1:0] chan_sel;
    logic [29:0][7:0] act_a;
    logic [29:0][7:0] act_b;
    int fail_count = 0;
    int total_checks = 0;
    int cycles = 0;
    logic lsb_mode = 1'b0;
    logic [7:0] rd;
    logic [31:0] r;
    row_s rows [8];

    serial_port_if link ();

    adc_serial_regs #(
        .CHIP_ID(8'hA7), // Arbitrary identification value
        .NPROG(30)
    ) adc_serial_regs_inst (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .port(link),
        .powerdown_o(powerdown),
        .lsb_first_o(lsb_first),
        .chan_sel_o(chan_sel),
        .prog_active_a_o(act_a),
        .prog_active_b_o(act_b)
    );

    serial_port_host #(.SCLK_HALF(HALF)) serial_port_host_inst (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .cyc_i(cyc),
        .stb_i(stb),
        .we_i(we),
        .adr_i(adr),
        .sel_i(sel),
        .dat_i(dat_w),
        .dat_o(dat_r),
        .ack_o(ack),
        .port(link)
    );

    dual_adc_props #(.HALF(HALF)) dual_adc_props_inst (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .sclk(link.sclk),
        .port_select_n(link.port_select_n),
        .host_sdio(link.host_sdio),
        .host_sdio_oe(link.host_sdio_oe),
        .dev_sdio(link.dev_sdio),
        .dev_sdio_oe(link.dev_sdio_oe),
        .serial_data_powerdown_pin(link.serial_data_powerdown_pin)
    );

    always #4 clk_i = ~clk_i;

    task automatic conclude();
        if (fail_count == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : conclude

    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            fail_count = fail_count + 1;
            conclude();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // Entered just after a rising edge; leaves one idle cycle behind
    task automatic wb(input logic wr, input logic [3:0] a, input logic [31:0] d,
                      output logic [31:0] q);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= wr;
        adr <= a;
        dat_w <= d;
        sel <= 4'hF;
        @(posedge clk_i);
        while (ack !== 1'b1) @(posedge clk_i);
        q = dat_r;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge clk_i);
    endtask : wb

    // One single-byte frame, then poll busy until the frame ends
    task automatic spi(input logic rw, input logic [12:0] a, input logic [7:0] d);
        logic [31:0] s;
        wb(1'b1, 4'h4, {19'h0_0000, a}, s);
        wb(1'b1, 4'h8, {24'h00_0000, d}, s);
        wb(1'b1, 4'h0, {29'h0000_0000, lsb_mode, rw, 1'b1}, s);
        s = 32'h0000_0001;
        while (s[0] !== 1'b0) wb(1'b0, 4'hC, 32'h0000_0000, s);
        rd = s[15:8];
    endtask : spi

    // Static level needs a few cycles to reach the line
    task automatic pd_wait(input logic e);
        for (int i = 0; i < 20 && powerdown !== e; i++) @(posedge clk_i);
    endtask : pd_wait

    initial begin
        rows = '{
            '{1'b0, 13'h0000, 8'h00, 8'h18},
            '{1'b0, 13'h0001, 8'h00, 8'hA7},
            '{1'b0, 13'h0002, 8'h00, 8'h00},
            '{1'b0, 13'h0005, 8'h00, 8'h03},
            '{1'b0, 13'h0009, 8'h00, 8'h01},
            '{1'b0, 13'h0013, 8'h00, 8'h00},
            '{1'b1, 13'h0008, 8'h01, 8'h00},
            '{1'b0, 13'h0008, 8'h00, 8'h01}
        };
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk(32'(lsb_first), 32'h0000_0000);
        chk(32'(chan_sel), 32'h0000_0003);
        chk(32'(act_a[1]), 32'h0000_0001);
        wb(1'b1, 4'h0, 32'h0000_0018, r);
        pd_wait(1'b1);
        chk(32'(powerdown), 32'h0000_0001);
        wb(1'b1, 4'h0, 32'h0000_0008, r);
        pd_wait(1'b0);
        chk(32'(powerdown), 32'h0000_0000);
        wb(1'b1, 4'h0, 32'h0000_0000, r);
        pd_wait(1'b1);
        chk(32'(powerdown), 32'h0000_0001);
        foreach (rows[i]) begin
            spi(!rows[i].wr, rows[i].addr, rows[i].data);
            if (!rows[i].wr) chk(32'(rd), 32'(rows[i].exp));
        end
        chk(32'(act_a[0]), 32'h0000_0000);
        chk(32'(powerdown), 32'h0000_0000);
        spi(1'b0, 13'h00FF, 8'h01);
        chk(32'(act_a[0]), 32'h0000_0001);
        chk(32'(act_b[0]), 32'h0000_0001);
        chk(32'(powerdown), 32'h0000_0001);
        spi(1'b1, 13'h00FF, 8'h00);
        chk(32'(rd), 32'h0000_0000);
        spi(1'b0, 13'h0008, 8'h00);
        chk(32'(act_a[0]), 32'h0000_0001);
        spi(1'b0, 13'h00FF, 8'h01);
        spi(1'b0, 13'h0005, 8'h01);
        chk(32'(chan_sel), 32'h0000_0001);
        spi(1'b0, 13'h000D, 8'h05);
        spi(1'b0, 13'h0009, 8'h00);
        spi(1'b0, 13'h0005, 8'h02);
        spi(1'b0, 13'h000D, 8'h06);
        spi(1'b0, 13'h00FF, 8'h01);
        chk(32'(act_a[5]), 32'h0000_0005);
        chk(32'(act_b[5]), 32'h0000_0006);
        chk(32'(act_b[1]), 32'h0000_0000);
        spi(1'b1, 13'h000D, 8'h00);
        chk(32'(rd), 32'h0000_0006);
        spi(1'b0, 13'h0005, 8'h03);
        spi(1'b1, 13'h000D, 8'h00);
        chk(32'(rd), 32'h0000_0005);
        spi(1'b0, 13'h000D, 8'h07);
        spi(1'b0, 13'h00FF, 8'h01);
        chk(32'(act_a[5]), 32'h0000_0007);
        chk(32'(act_b[5]), 32'h0000_0007);
        spi(1'b0, 13'h0000, 8'h5A);
        chk(32'(lsb_first), 32'h0000_0001);
        lsb_mode = 1'b1;
        spi(1'b1, 13'h0000, 8'h00);
        chk(32'(rd), 32'h0000_005A);
        spi(1'b1, 13'h0005, 8'h00);
        chk(32'(rd), 32'h0000_0003);
        spi(1'b0, 13'h0005, 8'h01);
        spi(1'b0, 13'h0000, 8'h3C);
        lsb_mode = 1'b0;
        chk(32'(lsb_first), 32'h0000_0000);
        chk(32'(chan_sel), 32'h0000_0003);
        spi(1'b0, 13'h0005, 8'h02);
        wb(1'b0, 4'h8, 32'h0000_0000, r);
        chk(r, 32'h0000_0002);
        wb(1'b0, 4'h4, 32'h0000_0000, r);
        chk(r, 32'h0000_0005);
        rst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk(32'(chan_sel), 32'h0000_0003);
        chk(32'(powerdown), 32'h0000_0001);
        conclude();
    end
endmodule : dual_adc_spi_register_map_bench
